// file: include/slsc_consts.svh
`ifndef SLSC_CONSTS_SVH
`define SLSC_CONSTS_SVH

// Register byte offsets, one aligned word each; TXLID and RXLID start windows of one word per lane
`define SLSC_OFF_CTRL 8'h00
`define SLSC_OFF_MFLEN 8'h04
`define SLSC_OFF_STATUS 8'h08
`define SLSC_OFF_TXLID 8'h20
`define SLSC_OFF_RXLID 8'h40

// Control word field positions
`define SLSC_CTRL_TX 0
`define SLSC_CTRL_C64 1
`define SLSC_CTRL_SC_LO 2
`define SLSC_CTRL_ALWAYS 4
`define SLSC_CTRL_REQ 5
`define SLSC_CTRL_LINKSYNC 6
`define SLSC_CTRL_DLY_LO 8

// Reset values
`define SLSC_CTRL_RESET 32'h0000_0044
`define SLSC_MFLEN_RESET 10'h010

// Widths and limits
`define SLSC_DLY_W 4
`define SLSC_CNT_W 10
`define SLSC_LID_W 5
`define SLSC_MAX_LANES 8

`endif

// file: include/slsc_pkg.sv
package slsc_pkg;
  `include "slsc_consts.svh"

  // Link bring-up phases
  typedef enum logic [1:0] {ST_WAIT_SYSREF, ST_WAIT_LINK, ST_RUN} slsc_state_type;

  // Software-held configuration and bus answer state
  typedef struct packed {
    logic [31:0] ctrl;
    logic [`SLSC_CNT_W-1:0] mfLen;
    logic [`SLSC_MAX_LANES*`SLSC_LID_W-1:0] txLid;
    logic waitReq;
    logic [31:0] rdData;
  } slsc_cfg_type;

  // Link-side state, loaded by the core reset: armed set, everything else cleared
  typedef struct packed {
    slsc_state_type state;
    logic [(1<<`SLSC_DLY_W)-1:0] dly;
    logic dlyPrev;
    logic [`SLSC_CNT_W-1:0] count;
    logic aligned;
    logic armed;
    logic syncOut;
    logic ilaStart;
    logic txMb;
    logic rxRelease;
    logic boundary;
    logic syncSeen;
    logic [7:0] eventCount;
  } slsc_link_type;
endpackage : slsc_pkg

// file: core/slsc_core.sv
// The register addresses and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/100ps
`include "slsc_consts.svh"
module slsc_core import slsc_pkg::*; #(
  parameter int LANES = 8
) (
  // Clock and resets
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cfgRst_n,
  // Avalon-MM register slave
  input wire logic [7:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [3:0] avs_byteenable,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // Link timing inputs
  input wire logic sysrefIn,
  input wire logic syncIn,
  input wire logic cgsDone,
  input wire logic resyncReq,
  input wire logic [LANES*`SLSC_LID_W-1:0] rxLaneIds,
  // Link control outputs
  output logic syncOut,
  output logic ilaStart,
  output logic txMbEnable,
  output logic rxDataRelease,
  output logic mfBoundary,
  output logic [`SLSC_CNT_W-1:0] mfCount,
  output logic [LANES*`SLSC_LID_W-1:0] laneIdOut
);

  // Refuse lane counts the register map cannot hold
  if (LANES < 1 || LANES > `SLSC_MAX_LANES) begin : g_lane_check
    $error("slsc_core: LANES must be 1 to 8");
  end

  // Write merge under byte enables
  function automatic logic [31:0] mergeBytes(input logic [31:0] old, input logic [31:0] wd,
                                             input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int b = 0; b < 4; b++) begin
      if (be[b]) begin
        res[8*b +: 8] = wd[8*b +: 8];
      end
    end
    return res;
  endfunction : mergeBytes

  // Lane index of an address inside a per-lane window, or -1
  function automatic int laneHit(input logic [7:0] addr, input logic [7:0] base);
    int idx;
    idx = -1;
    for (int i = 0; i < LANES; i++) begin
      if (addr == base + 8'(4 * i)) begin
        idx = i;
      end
    end
    return idx;
  endfunction : laneHit

  slsc_cfg_type cfg_reg;
  slsc_cfg_type cfg_next;
  slsc_link_type link_reg;
  slsc_link_type link_next;

  // Decoded control fields and derived link conditions
  logic txRole;
  logic coding64;
  logic [1:0] subclass;
  logic alwaysBit;
  logic reqBit;
  logic linkSyncBit;
  logic [`SLSC_DLY_W-1:0] dlyField;
  logic useSysref;
  logic sc2;
  logic dlyTap;
  logic sysEvt;
  logic take;
  logic wrap;
  logic running;
  logic bnd;
  logic resync;
  logic busReq;

  assign txRole = cfg_reg.ctrl[`SLSC_CTRL_TX];
  assign coding64 = cfg_reg.ctrl[`SLSC_CTRL_C64];
  assign subclass = cfg_reg.ctrl[`SLSC_CTRL_SC_LO +: 2];
  assign alwaysBit = cfg_reg.ctrl[`SLSC_CTRL_ALWAYS];
  assign reqBit = cfg_reg.ctrl[`SLSC_CTRL_REQ];
  assign linkSyncBit = cfg_reg.ctrl[`SLSC_CTRL_LINKSYNC];
  assign dlyField = cfg_reg.ctrl[`SLSC_CTRL_DLY_LO +: `SLSC_DLY_W];
  // Subclass 2 exists only with 8B10B; subclass 0 runs the counter free
  assign useSysref = (subclass == 2'h1);
  assign sc2 = (subclass == 2'h2) && !coding64;

  // Delayed SYSREF tap and rising-edge event
  assign dlyTap = link_reg.dly[dlyField];
  assign sysEvt = dlyTap && !link_reg.dlyPrev;
  // Only an armed counter, or always-realign, accepts the event
  assign take = sysEvt && useSysref && (link_reg.armed || alwaysBit);
  assign wrap = (link_reg.count == cfg_reg.mfLen - `SLSC_CNT_W'(1));
  assign running = link_reg.aligned || !useSysref;
  assign bnd = running && wrap && !take;
  // Resync: receiver is told, transmitter sees SYNC drop in 8B10B
  // A transmitter needs SYNC seen high first, so SYNC still low after reset is no request
  assign resync = (txRole && !coding64) ? (link_reg.syncSeen && !syncIn) : resyncReq;
  assign busReq = avs_read || avs_write;

  // Link sequencing: counter alignment, bring-up and resync
  always_comb begin
    link_next = link_reg;
    // Sixteen taps cost flops but give every delay value exactly one clock per unit
    link_next.dly = {link_reg.dly[(1<<`SLSC_DLY_W)-2:0], sysrefIn};
    link_next.dlyPrev = dlyTap;
    link_next.syncSeen = syncIn;
    link_next.ilaStart = 1'b0;
    link_next.boundary = bnd;
    if (sysEvt) begin
      link_next.eventCount = link_reg.eventCount + 8'h01;
    end
    // Local counter: restart on an accepted event, else free-run once aligned or when SYSREF is unused
    if (take) begin
      link_next.count = '0;
      link_next.aligned = 1'b1;
      link_next.armed = 1'b0;
    end else if (running) begin
      link_next.count = wrap ? '0 : link_reg.count + `SLSC_CNT_W'(1);
    end else begin
      link_next.count = '0;
    end
    case (link_reg.state)
      ST_WAIT_SYSREF: begin
        // Nothing leaves until the counter is aligned, or at once when SYSREF is unused
        link_next.syncOut = 1'b0;
        link_next.txMb = 1'b0;
        link_next.rxRelease = 1'b0;
        if (!useSysref || link_reg.aligned) begin
          link_next.state = ST_WAIT_LINK;
        end
      end
      ST_WAIT_LINK: begin
        if (coding64) begin
          if (txRole) begin
            link_next.txMb = 1'b1;
            link_next.state = ST_RUN;
          end else if (cgsDone && bnd) begin
            link_next.rxRelease = 1'b1;
            link_next.state = ST_RUN;
          end
        end else if (txRole) begin
          // Transmitter waits for SYNC, then the next boundary
          if (syncIn && bnd) begin
            link_next.ilaStart = !sc2 || linkSyncBit;
            link_next.txMb = 1'b1;
            link_next.state = ST_RUN;
          end
        end else if (sc2) begin
          // Subclass 2 receiver asserts SYNC as soon as cgsDone is seen, without waiting for a boundary
          if (cgsDone) begin
            link_next.syncOut = 1'b1;
            link_next.state = ST_RUN;
          end
        end else if (cgsDone && bnd) begin
          link_next.syncOut = 1'b1;
          link_next.rxRelease = 1'b1;
          link_next.state = ST_RUN;
        end
      end
      ST_RUN: begin
        // Subclass 2 receiver releases data only on its own boundary
        if (sc2 && !txRole && !link_reg.rxRelease && bnd) begin
          link_next.rxRelease = 1'b1;
        end
        if (resync) begin
          link_next.rxRelease = 1'b0;
          link_next.syncOut = 1'b0;
          if (reqBit && useSysref) begin
            // Forget the alignment and repeat the initial bring-up
            link_next.aligned = 1'b0;
            link_next.armed = 1'b1;
            link_next.count = '0;
            link_next.txMb = 1'b0;
            link_next.state = ST_WAIT_SYSREF;
          end else begin
            // Counter keeps running; a 64B66B transmitter never stops
            link_next.txMb = coding64 && txRole;
            // Re-arm so that the first event after this resync may realign
            if (!reqBit) begin
              link_next.armed = 1'b1;
            end
            link_next.state = ST_WAIT_LINK;
          end
        end
      end
      default: begin
        link_next.state = ST_WAIT_SYSREF;
      end
    endcase
  end

  // Link flops; the core reset leaves the configuration alone
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      link_reg <= '{state: ST_WAIT_SYSREF, armed: 1'b1, default: '0};
    end else begin
      link_reg <= link_next;
    end
  end

  // Register file: one wait cycle, then the answer
  always_comb begin
    int li;
    int ri;
    logic [31:0] lenWord;
    cfg_next = cfg_reg;
    li = laneHit(avs_address, `SLSC_OFF_TXLID);
    ri = laneHit(avs_address, `SLSC_OFF_RXLID);
    lenWord = mergeBytes({22'h000000, cfg_reg.mfLen}, avs_writedata, avs_byteenable);
    cfg_next.waitReq = !(busReq && cfg_reg.waitReq);
    if (busReq && cfg_reg.waitReq) begin
      // Unmapped words read as zero
      cfg_next.rdData = 32'h0000_0000;
      if (avs_address == `SLSC_OFF_CTRL) begin
        cfg_next.rdData = cfg_reg.ctrl;
      end else if (avs_address == `SLSC_OFF_MFLEN) begin
        cfg_next.rdData = {22'h000000, cfg_reg.mfLen};
      end else if (avs_address == `SLSC_OFF_STATUS) begin
        cfg_next.rdData = {link_reg.eventCount, 14'h0000, link_reg.count};
      end else if (li >= 0) begin
        cfg_next.rdData[`SLSC_LID_W-1:0] = cfg_reg.txLid[li*`SLSC_LID_W +: `SLSC_LID_W];
      end else if (ri >= 0 && !coding64) begin
        cfg_next.rdData[`SLSC_LID_W-1:0] = rxLaneIds[ri*`SLSC_LID_W +: `SLSC_LID_W];
      end
      cfg_next.rdData[31:0] = cfg_next.rdData;
    end
    // Status word bits 17:10 carry state bits instead of spare zeros
    if (busReq && cfg_reg.waitReq && avs_address == `SLSC_OFF_STATUS) begin
      cfg_next.rdData[17:10] = {link_reg.state, link_reg.aligned, link_reg.armed,
                                link_reg.syncOut, link_reg.txMb, link_reg.rxRelease,
                                link_reg.ilaStart};
    end
    // Writes land at the edge that completes the transfer
    if (avs_write && !cfg_reg.waitReq) begin
      if (avs_address == `SLSC_OFF_CTRL) begin
        cfg_next.ctrl = mergeBytes(cfg_reg.ctrl, avs_writedata, avs_byteenable);
      end else if (avs_address == `SLSC_OFF_MFLEN) begin
        cfg_next.mfLen = lenWord[`SLSC_CNT_W-1:0];
      end else if (li >= 0 && avs_byteenable[0]) begin
        // Lane ids take byte lane 0 only; the rest of the word is ignored
        cfg_next.txLid[li*`SLSC_LID_W +: `SLSC_LID_W] = avs_writedata[`SLSC_LID_W-1:0];
      end
    end
  end

  // Configuration flops survive the core reset
  // A separate reset lets software keep its setup across link restarts
  always_ff @(posedge clock or negedge cfgRst_n) begin
    if (!cfgRst_n) begin
      cfg_reg <= '{ctrl: `SLSC_CTRL_RESET, mfLen: `SLSC_MFLEN_RESET, waitReq: 1'b1,
                   default: '0};
    end else begin
      cfg_reg <= cfg_next;
    end
  end

  // Outputs straight from flops
  assign avs_readdata = cfg_reg.rdData;
  assign avs_waitrequest = cfg_reg.waitReq;
  assign syncOut = link_reg.syncOut;
  assign ilaStart = link_reg.ilaStart;
  assign txMbEnable = link_reg.txMb;
  assign rxDataRelease = link_reg.rxRelease;
  assign mfBoundary = link_reg.boundary;
  assign mfCount = link_reg.count;
  assign laneIdOut = cfg_reg.txLid[LANES*`SLSC_LID_W-1:0];

  // Checks on the sequencing
  default clocking cb @(posedge clock); endclocking
  default disable iff (!rst_n || !cfgRst_n);

  // Counter alignment and the delayed event
  a_event_realign: assert property (take |=> link_reg.count == '0 && link_reg.aligned)
    else $error("accepted SYSREF did not realign counter");
  a_ignore_later: assert property ((sysEvt && !link_reg.armed && !alwaysBit &&
    link_reg.aligned && !wrap && $stable(cfg_reg.mfLen)) |=>
    link_reg.count == $past(link_reg.count) + `SLSC_CNT_W'(1))
    else $error("unarmed SYSREF disturbed counter");
  // With a delay of three the event lands on the fourth edge after the rise
  a_delay_tap: assert property ((dlyField == 4'h3 && $rose(sysrefIn)) ##1
    (dlyField == 4'h3)[*4] |-> sysEvt)
    else $error("delayed SYSREF event not at programmed delay");
  a_event_count: assert property (sysEvt |=>
    link_reg.eventCount == $past(link_reg.eventCount) + 8'h01)
    else $error("SYSREF event not counted");
  a_count_held: assert property ((useSysref && !link_reg.aligned) |-> link_reg.count == '0)
    else $error("counter ran before SYSREF");

  // Bring-up waits for SYSREF, then lands on a boundary
  a_sync_withheld: assert property ((!coding64 && !txRole && useSysref &&
    !link_reg.aligned) |-> !link_reg.syncOut)
    else $error("SYNC asserted before alignment");
  a_sync_boundary: assert property ((!sc2 && !coding64 && !txRole &&
    $rose(link_reg.syncOut)) |-> link_reg.boundary)
    else $error("SYNC not raised on a boundary");
  a_ila_sysref: assert property (link_reg.ilaStart |-> (link_reg.aligned || !useSysref))
    else $error("alignment sequence before SYSREF");
  a_ila_boundary: assert property (link_reg.ilaStart |-> link_reg.boundary)
    else $error("alignment sequence off boundary");
  a_mb_held: assert property ((coding64 && txRole && useSysref && !link_reg.aligned)
    |-> !link_reg.txMb)
    else $error("multiblocks sent before SYSREF");
  a_wait_sysref: assert property ((link_reg.state == ST_WAIT_SYSREF && useSysref &&
    !link_reg.aligned) |=> link_reg.state == ST_WAIT_SYSREF)
    else $error("bring-up left before SYSREF");
  a_rx64_release: assert property ((coding64 && !txRole &&
    $rose(link_reg.rxRelease)) |-> link_reg.boundary)
    else $error("64B66B data released off boundary");
  a_sc2_release: assert property ((sc2 && !txRole && $rose(link_reg.rxRelease))
    |-> link_reg.boundary)
    else $error("subclass 2 data released off boundary");

  // Resync handling
  a_resync_drop: assert property ((!coding64 && txRole && link_reg.state == ST_RUN &&
    link_reg.syncSeen && !syncIn) |=> !link_reg.txMb)
    else $error("SYNC drop not taken as resync");
  a_resync_stall: assert property ((link_reg.state == ST_RUN && resync && reqBit &&
    useSysref) |=> link_reg.state == ST_WAIT_SYSREF ##1 !link_reg.syncOut)
    else $error("resync did not stall for SYSREF");
  a_auto_restart: assert property ((link_reg.state == ST_RUN && resync && !reqBit)
    |=> link_reg.state == ST_WAIT_LINK)
    else $error("resync did not restart link");
  a_tx_keeps: assert property ((coding64 && txRole && link_reg.state == ST_RUN &&
    resync && !reqBit) |=> link_reg.txMb)
    else $error("64B66B transmitter stopped on resync");
  // The slave answers every request one cycle after taking it
  a_bus_answer: assert property ((busReq && avs_waitrequest) |=> !avs_waitrequest ##1
    avs_waitrequest)
    else $error("bus answer not one cycle later");

  c_take: cover property (take);
  c_ila: cover property (link_reg.ilaStart);
  c_stall: cover property (link_reg.state == ST_RUN ##1 link_reg.state == ST_WAIT_SYSREF);
  c_release: cover property ($rose(link_reg.rxRelease));
  c_ignored: cover property (sysEvt && !take && useSysref);

endmodule : slsc_core

// file: tb/slsc_conv_model.sv
`timescale 1ns/100ps
module slsc_conv_model (
  // Clock and core reset
  input wire logic clock,
  input wire logic rst_n,
  // Bench commands
  input wire logic fire,
  input wire logic lockReq,
  input wire logic syncReq,
  input wire logic [39:0] ids,
  // Pins toward the core
  output logic sysrefIn,
  output logic syncIn,
  output logic cgsDone,
  output logic [39:0] rxLaneIds
);
  logic [1:0] pulse_reg = 2'h0;
  logic [2:0] lock_reg = 3'h0;
  logic sync_reg = 1'b0;
  // Pulse launched on the core edge; dropped in reset, a lost one-shot never aligns
  always @(posedge clock) begin
    pulse_reg <= {pulse_reg[0], fire & rst_n};
    sync_reg <= syncReq;
    // Lock takes seven cycles on purpose, a slow converter
    if (!lockReq) lock_reg <= 3'h0;
    else if (lock_reg != 3'h7) lock_reg <= lock_reg + 3'h1;
  end
  // Pin levels
  assign sysrefIn = |pulse_reg;
  assign syncIn = sync_reg;
  assign cgsDone = lock_reg == 3'h7;
  assign rxLaneIds = ids;
endmodule : slsc_conv_model

// file: tb/tb.sv
`timescale 1ns/100ps
`include "slsc_consts.svh"
module tb;
  logic clock = 1'b0, rst_n = 1'b0, cfgRst_n = 1'b0;
  logic [7:0] avs_address = 8'h00;
  logic avs_read = 1'b0, avs_write = 1'b0;
  logic [3:0] avs_byteenable = 4'hf;
  logic [31:0] avs_writedata = 32'h0, avs_readdata, rdq, ctlExp;
  logic avs_waitrequest, sysrefIn, syncIn, cgsDone, hit, mbLow;
  logic fire = 1'b0, lockReq = 1'b0, syncReq = 1'b0, resyncReq = 1'b0;
  logic syncOut, ilaStart, txMbEnable, rxDataRelease, mfBoundary;
  logic [9:0] mfCount;
  logic [39:0] ids = 40'h0, lane_identifier, rxLaneIds, laneIdOut;
  logic [4:0] outs;
  int failures = 0, cmp_count = 0, i, dly;

  // 25 MHz core clock
  always #20 clock = ~clock;
  assign outs = {mfBoundary, txMbEnable, ilaStart, rxDataRelease, syncOut};

  slsc_core #(.LANES(8)) u_slsc_core (.clock(clock), .rst_n(rst_n), .cfgRst_n(cfgRst_n),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_byteenable(avs_byteenable), .avs_writedata(avs_writedata),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .sysrefIn(sysrefIn),
    .syncIn(syncIn), .cgsDone(cgsDone), .resyncReq(resyncReq), .rxLaneIds(rxLaneIds),
    .syncOut(syncOut), .ilaStart(ilaStart), .txMbEnable(txMbEnable),
    .rxDataRelease(rxDataRelease), .mfBoundary(mfBoundary), .mfCount(mfCount),
    .laneIdOut(laneIdOut));
  slsc_conv_model u_slsc_conv_model (.clock(clock), .rst_n(rst_n), .fire(fire),
    .lockReq(lockReq), .syncReq(syncReq), .ids(ids), .sysrefIn(sysrefIn), .syncIn(syncIn),
    .cgsDone(cgsDone), .rxLaneIds(rxLaneIds));

  task automatic summarize;
    $display("checks %0d mismatches %0d", cmp_count, failures);
    if (failures == 0 && cmp_count > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : summarize

  task automatic check(input string what, input logic [39:0] exp, input logic [39:0] got);
    cmp_count++;
    if (got !== exp) begin
      failures++;
      $display("mismatch %s expected %0h seen %0h", what, exp, got);
    end
  endtask : check

  // Avalon master: request held until waitrequest is sampled low
  task automatic busOp(input logic wr, input logic [7:0] a, input logic [31:0] d,
      input logic [3:0] be);
    int n;
    @(posedge clock);
    avs_address <= a;
    avs_writedata <= d;
    avs_byteenable <= be;
    avs_read <= !wr;
    avs_write <= wr;
    for (n = 0; n < 20; n++) begin
      @(posedge clock);
      if (avs_waitrequest === 1'b0) break;
    end
    rdq = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    if (n == 20) begin
      failures++;
      summarize();
    end
  endtask : busOp

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    busOp(1'b1, a, d, 4'hf);
  endtask : wr

  task automatic rd(input logic [7:0] a);
    busOp(1'b0, a, 32'h0, 4'hf);
  endtask : rd

  function automatic logic [31:0] ctl(input int tx, c64, sc, alw, rq, ls, d);
    return 32'((tx << `SLSC_CTRL_TX) | (c64 << `SLSC_CTRL_C64) | (sc << `SLSC_CTRL_SC_LO)
      | (alw << `SLSC_CTRL_ALWAYS) | (rq << `SLSC_CTRL_REQ)
      | (ls << `SLSC_CTRL_LINKSYNC) | (d << `SLSC_CTRL_DLY_LO));
  endfunction : ctl

  task automatic setCtl(input int tx, c64, sc, alw, rq, ls, d);
    ctlExp = ctl(tx, c64, sc, alw, rq, ls, d);
    wr(`SLSC_OFF_CTRL, ctlExp);
  endtask : setCtl

  task automatic coreReset;
    @(posedge clock);
    rst_n <= 1'b0;
    @(posedge clock);
    rst_n <= 1'b1;
  endtask : coreReset

  task automatic pulseSysref;
    @(posedge clock);
    fire <= 1'b1;
    @(posedge clock);
    fire <= 1'b0;
  endtask : pulseSysref

  // Looks for an output at settled negedges; a required one that never comes ends the run
  task automatic watch(input int idx, input int n, input logic must);
    hit = 1'b0;
    for (int k = 0; k < n && !hit; k++) begin
      @(negedge clock);
      hit = (outs[idx] === 1'b1);
    end
    if (must && !hit) begin
      failures++;
      summarize();
    end
  endtask : watch

  // Fires just after a boundary so the drop is seen before the next one
  task automatic resync;
    watch(4, 200, 1'b1);
    @(posedge clock);
    resyncReq <= 1'b1;
    @(posedge clock);
    resyncReq <= 1'b0;
    // Any low multiblock enable in the settling cycles is remembered
    mbLow = 1'b0;
    repeat (4) begin
      @(negedge clock);
      mbLow = mbLow | (txMbEnable !== 1'b1);
    end
  endtask : resync

  // SYSREF launched when the counter reads 10; phase checked after the delay
  task automatic fireAt(input int d, input logic re);
    int n;
    for (n = 0; n < 200; n++) begin
      @(negedge clock);
      if (mfCount === 10'h00a) break;
    end
    if (n == 200) begin
      failures++;
      summarize();
    end
    pulseSysref();
    repeat (3 + d) @(negedge clock);
    check("counter phase", re ? 0 : 14 + d, mfCount);
  endtask : fireAt

  // Main sequence
  initial begin
    void'($urandom(71568));
    repeat (16) @(posedge clock);
    rst_n <= 1'b1;
    cfgRst_n <= 1'b1;
    rd(`SLSC_OFF_CTRL);
    check("ctrl reset", `SLSC_CTRL_RESET, rdq);
    rd(`SLSC_OFF_MFLEN);
    check("mflen reset", `SLSC_MFLEN_RESET, rdq);
    rd(8'h80);
    check("unmapped read", 0, rdq);
    // Lane 3 stays zero; a write without byte 0 must not land
    for (i = 0; i < 8; i++) begin
      lane_identifier[i*5+:5] = (i == 3) ? 5'h00 : 5'($urandom);
      wr(8'(32 + 4 * i), 32'(lane_identifier[i*5+:5]));
    end
    busOp(1'b1, 8'h20, 32'(~lane_identifier[4:0]), 4'he);
    rd(8'h20);
    check("lane id 0", lane_identifier[4:0], rdq);
    check("lane id out", lane_identifier, laneIdOut);
    ids <= 40'({$urandom, $urandom});
    for (i = 0; i < 8; i++) begin
      rd(8'(64 + 4 * i));
      check("rx lane id", ids[i*5+:5], rdq);
    end
    wr(`SLSC_OFF_MFLEN, 32'h40);
    // Receiver, 8B10B subclass 1
    setCtl(0, 0, 1, 1, 0, 1, 0);
    coreReset();
    lockReq <= 1'b1;
    watch(0, 120, 1'b0);
    check("sync before sysref", 0, hit);
    pulseSysref();
    watch(0, 200, 1'b1);
    check("sync at boundary", 1, mfBoundary);
    rd(`SLSC_OFF_STATUS);
    check("event count", 1, rdq[31:24]);
    check("link state", 2, rdq[17:16]);
    for (i = 0; i < 4; i++) begin
      dly = (i == 0) ? 0 : (i == 1) ? 15 : (i == 2) ? 3 : $urandom % 16;
      setCtl(0, 0, 1, i < 3, 0, 1, dly);
      fireAt(dly, i < 3);
    end
    setCtl(0, 0, 1, 0, 1, 1, 0);
    resync();
    check("sync dropped", 0, syncOut);
    watch(0, 150, 1'b0);
    check("stalled without sysref", 0, hit);
    pulseSysref();
    watch(0, 200, 1'b1);
    check("sync after sysref", 1, mfBoundary);
    setCtl(0, 0, 1, 0, 0, 1, 0);
    resync();
    check("sync dropped", 0, syncOut);
    watch(0, 200, 1'b1);
    check("auto restart", 1, mfBoundary);
    // Transmitter, 8B10B subclass 1
    syncReq <= 1'b1;
    setCtl(1, 0, 1, 0, 0, 1, 0);
    coreReset();
    watch(2, 120, 1'b0);
    check("ila before sysref", 0, hit);
    pulseSysref();
    watch(2, 200, 1'b1);
    check("ila at boundary", 1, mfBoundary);
    @(posedge clock);
    syncReq <= 1'b0;
    watch(2, 100, 1'b0);
    check("ila while sync low", 0, hit);
    @(posedge clock);
    syncReq <= 1'b1;
    watch(2, 200, 1'b1);
    check("ila after resync", 1, mfBoundary);
    // Transmitter, 64B66B
    setCtl(1, 1, 1, 0, 0, 1, 0);
    coreReset();
    watch(3, 120, 1'b0);
    check("blocks before sysref", 0, hit);
    pulseSysref();
    watch(3, 200, 1'b1);
    resync();
    check("tx keeps sending", 1, txMbEnable);
    check("tx never paused", 0, mbLow);
    // Receiver, 64B66B
    setCtl(0, 1, 1, 0, 0, 1, 0);
    coreReset();
    repeat (60) @(negedge clock);
    check("counter held", 0, mfCount);
    rd(8'h44);
    check("no lane id", 0, rdq);
    pulseSysref();
    repeat (13) @(negedge clock);
    check("counter started", 10, mfCount);
    // Subclass 0 runs the counter free; SYNC comes on a boundary with no SYSREF
    setCtl(0, 0, 0, 0, 0, 1, 0);
    coreReset();
    watch(0, 200, 1'b1);
    check("free-run sync at boundary", 1, mfBoundary);
    // Subclass 2, receiver then transmitter with and without alignment sequence
    setCtl(0, 0, 2, 0, 0, 1, 0);
    coreReset();
    watch(0, 30, 1'b1);
    watch(1, 200, 1'b1);
    check("release at boundary", 1, mfBoundary);
    for (i = 0; i < 2; i++) begin
      setCtl(1, 0, 2, 0, 0, i, 0);
      coreReset();
      rd(`SLSC_OFF_CTRL);
      check("ctrl kept", ctlExp, rdq);
      watch(3, 200, 1'b1);
      check("tx at boundary", 1, mfBoundary);
      check("ila by link sync", i, ilaStart);
    end
    summarize();
  end
endmodule : tb
